// ---- core/bss_sequencer.sv ----
// Start-up, soft-start, pre-bias and overcurrent sequencer for a buck controller.
// Assumes comparator and analog results arrive synchronous to clk as codes in mV.
// Operation
// R1 - Undervoltage: oscillator stopped, both gates off
// R2 - Start needs supply good and enable low
// R3 - Enable counts only when pulled well low
// R4 - Calibrate current sense before soft-start
// R5 - Sample sensed current at fixed time
// R6 - Pick low, middle or high trip level
// R7 - Latch level, disconnect sensing, then soft-start
// R8 - Reference ramps at constant rate, then holds
// R9 - Ramp time proportional to external reference
// R10 - Current limit active throughout soft-start
// R11 - Pulses wait until ramp exceeds feedback
// R12 - Low-side starts narrow, widens each cycle
// R13 - Widen until meeting high-side fall, then sync
// R14 - Output above target: rectifier on at end
// R15 - Blank comparator; compare only while fully on
// R16 - Overcurrent pulse ends high-side pulse immediately
// R17 - Counter up after pulse, down otherwise
// R18 - Limit reached: fault, both gates off
// R19 - Timeout of seven soft-start periods, then retry
// R20 - Switching clock fixed internal frequency
// R21 - High-side duty capped below full period
// R22 - Counter floors at zero, cleared on restart
`timescale 1ns/1ps
module bss_sequencer #(
  parameter int CAL_SAMPLE_CYC = bss_pkg::CAL_SAMPLE_CYC,
  parameter int CAL_END_CYC    = bss_pkg::CAL_END_CYC,
  parameter int SS_PERIOD_CYC  = bss_pkg::SS_PERIOD_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     supply_ok,
  input  wire logic                     enable_n,
  input  wire logic [1:0]               overload_trip_current,
  input  wire logic [bss_pkg::MV_W-1:0] external_reference_pin,
  input  wire logic [bss_pkg::MV_W-1:0] feedback_input,
  input  wire logic [5:0]               duty_cmd,
  input  wire logic [9:0]               hs_drop_mv,
  output logic                          high_side_gate_drive,
  output logic                          low_side_gate_drive,
  output logic                          cal_sense_on,
  output logic [1:0]                    overload_trip_level,
  output logic [bss_pkg::MV_W-1:0]      soft_start_ref,
  output logic                          fault_active,
  output logic                          regulating
);

  localparam int TW = bss_pkg::TMR_W;
  localparam int MW = bss_pkg::MV_W;

  bss_pkg::bss_state_type state_r;
  bss_pkg::bss_state_type state_nxt;
  logic [TW-1:0]              tmr_r;
  logic [2:0]                 per_cnt_r;
  logic [bss_pkg::STEP_W-1:0] step_r;
  logic [MW-1:0]              ss_ref_r;
  logic [5:0]                 phase_r;
  logic [5:0]                 ls_w_r;
  logic                       pulses_en_r;
  logic                       full_sync_r;
  logic                       oc_kill_r;
  logic                       oc_seen_r;
  logic                       hs_r;
  logic                       ls_r;
  logic                       cal_sense_r;
  logic [1:0]                 trip_sel_r;
  logic                       fault_r;
  logic                       reg_r;
  logic [bss_pkg::FC_W-1:0]   fc_count;
  logic                       fc_trip;

  ////////////////////////////////////////////////////////////////////////////
  // Qualifying conditions and timer decodes
  wire en_ok      = supply_ok && !enable_n;                        // see R2 R3
  wire cal_sample = (state_r == bss_pkg::S_CAL) && (tmr_r == TW'(CAL_SAMPLE_CYC - 1)); // see R5
  wire cal_done   = (state_r == bss_pkg::S_CAL) && (tmr_r == TW'(CAL_END_CYC - 1));
  wire ss_tick    = (tmr_r == TW'(SS_PERIOD_CYC - 1));
  wire to_done    = (state_r == bss_pkg::S_FAULT) && ss_tick &&
                    (per_cnt_r == bss_pkg::TIMEOUT_PERIODS - 3'h1); // see R19
  wire step_end   = (step_r == bss_pkg::STEP_W'(bss_pkg::SS_STEP_CYC - 1));
  wire ramp_top   = (ss_ref_r >= external_reference_pin);          // see R8 R9
  wire active     = (state_r == bss_pkg::S_SOFT) || (state_r == bss_pkg::S_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Switching timebase; stops whenever the supply is low
  wire period_end = (phase_r == bss_pkg::SW_PERIOD_CYC - 6'h01);   // see R20
  wire [5:0] phase_nxt = (!supply_ok || period_end) ? 6'h00 : phase_r + 6'h01; // see R1

  ////////////////////////////////////////////////////////////////////////////
  // Calibration decode: large current means low-resistance strap
  wire [1:0] trip_decode =
    (overload_trip_current == bss_pkg::CUR_LARGE) ? bss_pkg::TRIP_LOW :   // see R6
    (overload_trip_current == bss_pkg::CUR_SMALL) ? bss_pkg::TRIP_HIGH :  // see R6
    bss_pkg::TRIP_MID;                                                     // see R6
  wire [9:0] trip_mv =
    (trip_sel_r == bss_pkg::TRIP_LOW)  ? bss_pkg::TRIP_LOW_MV :
    (trip_sel_r == bss_pkg::TRIP_HIGH) ? bss_pkg::TRIP_HIGH_MV :
    bss_pkg::TRIP_MID_MV;

  ////////////////////////////////////////////////////////////////////////////
  // High-side pulse: duty clamp keeps a bootstrap recharge gap every cycle
  wire [5:0] hs_len   = (duty_cmd > bss_pkg::HS_MAX_ON_CYC) ? bss_pkg::HS_MAX_ON_CYC
                                                            : duty_cmd; // see R21
  wire pwm_act        = active && en_ok && pulses_en_r && !fc_trip;    // see R11 R18
  // Comparator window opens only after blanking, while the switch is on
  wire oc_win         = hs_r && (phase_r > bss_pkg::BLANK_CYC);        // see R15
  wire oc_pulse       = oc_win && active && (hs_drop_mv > trip_mv);    // see R10 R15
  wire hs_want        = pwm_act && (phase_nxt < hs_len) && !oc_pulse &&
                        !(oc_kill_r && !period_end);                   // see R16

  ////////////////////////////////////////////////////////////////////////////
  // Low-side pulse: ends at period end, leading edge walks earlier
  wire [5:0] ls_start = bss_pkg::SW_PERIOD_CYC - ls_w_r;
  wire       meets_hs = (ls_start <= hs_len);                          // see R13
  wire       ls_phase = full_sync_r ? (phase_nxt >= hs_len) || (oc_kill_r || oc_pulse)
                                    : (phase_nxt >= ls_start) && (ls_w_r != 6'h00); // see R12
  wire       ls_want  = pwm_act && !hs_want && !hs_r && ls_phase;
  wire       prebias_high = (feedback_input > external_reference_pin); // see R14

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state; disable or undervoltage wins over everything
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bss_pkg::S_OFF:   if (en_ok) state_nxt = bss_pkg::S_CAL;          // see R2
      bss_pkg::S_CAL:   if (cal_done) state_nxt = bss_pkg::S_SOFT;      // see R4 R7
      bss_pkg::S_SOFT: begin
        if (fc_trip) state_nxt = bss_pkg::S_FAULT;                     // see R18
        else if (ramp_top) state_nxt = bss_pkg::S_RUN;
      end
      bss_pkg::S_RUN:   if (fc_trip) state_nxt = bss_pkg::S_FAULT;      // see R18
      bss_pkg::S_FAULT: if (to_done) state_nxt = bss_pkg::S_CAL;        // see R19
      default:          state_nxt = bss_pkg::S_OFF;
    endcase
    if (!en_ok) begin
      state_nxt = bss_pkg::S_OFF;                                      // see R1 R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer restarts on each state change; wraps per soft-start period in fault
  wire [TW-1:0] tmr_nxt = (state_nxt != state_r) ? '0 :
                          (state_r == bss_pkg::S_FAULT && ss_tick) ? '0 :
                          (state_r == bss_pkg::S_CAL || state_r == bss_pkg::S_FAULT)
                            ? tmr_r + 1'b1 : '0;
  wire [2:0] per_cnt_nxt = (state_r != bss_pkg::S_FAULT) ? 3'h0 :
                           ss_tick ? per_cnt_r + 3'h1 : per_cnt_r;

  // Sequence state and timers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r   <= bss_pkg::S_OFF;
      tmr_r     <= '0;
      per_cnt_r <= 3'h0;
      phase_r   <= 6'h00;
    end else begin
      state_r   <= state_nxt;
      tmr_r     <= tmr_nxt;
      per_cnt_r <= per_cnt_nxt;
      phase_r   <= phase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp: 1 mV per step, held at the external reference once reached
  wire [MW-1:0] ss_ref_nxt =
    (state_r == bss_pkg::S_RUN) ? external_reference_pin :             // see R8
    (state_r != bss_pkg::S_SOFT) ? '0 :
    (step_end && !ramp_top) ? ss_ref_r + 1'b1 : ss_ref_r;              // see R8 R9
  wire [bss_pkg::STEP_W-1:0] step_nxt =
    (state_r != bss_pkg::S_SOFT || step_end) ? '0 : step_r + 1'b1;

  always_ff @(posedge clk) begin
    if (srst) begin
      ss_ref_r <= '0;
      step_r   <= '0;
    end else begin
      ss_ref_r <= ss_ref_nxt;
      step_r   <= step_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration capture: trip level frozen outside the sample point
  wire [1:0] trip_nxt  = cal_sample ? trip_decode : trip_sel_r;        // see R5 R7
  wire       sense_nxt = (state_nxt == bss_pkg::S_CAL);                // see R7

  always_ff @(posedge clk) begin
    if (srst) begin
      trip_sel_r  <= bss_pkg::TRIP_MID;
      cal_sense_r <= 1'b0;
    end else begin
      trip_sel_r  <= trip_nxt;
      cal_sense_r <= sense_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pre-bias gating and low-side width growth; reset on every restart
  // Output held above target: rectifier must still come on at ramp end
  wire pulses_nxt = !active ? 1'b0 :
                    (pulses_en_r || ss_ref_r > feedback_input) ||      // see R11
                    (state_r == bss_pkg::S_SOFT && ramp_top && prebias_high); // see R14
  wire [5:0] ls_w_nxt = !pulses_en_r ? 6'h00 :
                        (period_end && !full_sync_r) ? ls_w_r + 6'h01 : ls_w_r; // see R12
  wire sync_nxt = !active ? 1'b0 :
                  full_sync_r ||
                  (pulses_en_r && ls_w_r != 6'h00 && meets_hs) ||      // see R13
                  (state_r == bss_pkg::S_SOFT && ramp_top && prebias_high); // see R14
  // Kill latch lasts to the end of the present period
  wire kill_nxt = oc_pulse || (oc_kill_r && !period_end);              // see R16
  wire seen_nxt = period_end ? 1'b0 : (oc_seen_r || oc_pulse);
  wire fc_clear = !active;                                             // see R22

  always_ff @(posedge clk) begin
    if (srst) begin
      pulses_en_r <= 1'b0;
      ls_w_r      <= 6'h00;
      full_sync_r <= 1'b0;
      oc_kill_r   <= 1'b0;
      oc_seen_r   <= 1'b0;
    end else begin
      pulses_en_r <= pulses_nxt;
      ls_w_r      <= ls_w_nxt;
      full_sync_r <= sync_nxt;
      oc_kill_r   <= kill_nxt;
      oc_seen_r   <= seen_nxt;
    end
  end

  // Counts per switching period, an overcurrent pulse in the last cycle counts too
  bss_fault_counter #(
    .FC_W       (bss_pkg::FC_W)
  ) u_fault_counter (
    .clk        (clk),
    .srst       (srst),
    .clear      (fc_clear),
    .period_end (period_end),
    .oc_any     (oc_seen_r || oc_pulse),                               // see R17
    .count      (fc_count),
    .trip       (fc_trip)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin drives and status
  always_ff @(posedge clk) begin
    if (srst) begin
      hs_r    <= 1'b0;
      ls_r    <= 1'b0;
      fault_r <= 1'b0;
      reg_r   <= 1'b0;
    end else begin
      hs_r    <= hs_want;                                              // see R1 R18
      ls_r    <= ls_want;                                              // see R1 R18
      fault_r <= (state_nxt == bss_pkg::S_FAULT);
      reg_r   <= (state_nxt == bss_pkg::S_RUN);
    end
  end

  assign high_side_gate_drive = hs_r;
  assign low_side_gate_drive  = ls_r;
  assign cal_sense_on         = cal_sense_r;
  assign overload_trip_level  = trip_sel_r;
  assign soft_start_ref       = ss_ref_r;
  assign fault_active         = fault_r;
  assign regulating           = reg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_supply_undervoltage_lockout_gates_off: assert property (!supply_ok |=> !hs_r && !ls_r) // see R1
    else $error("gate on after undervoltage");
  a_start_gated: assert property ((state_r == bss_pkg::S_OFF && !en_ok) // see R2
    |=> state_r == bss_pkg::S_OFF)
    else $error("start without enable");
  a_cal_first: assert property ((state_r != bss_pkg::S_SOFT) ##1 // see R4
    (state_r == bss_pkg::S_SOFT) |-> $past(state_r) == bss_pkg::S_CAL)
    else $error("soft-start without calibration");
  a_trip_sampled: assert property (cal_sample |=> trip_sel_r == $past(trip_decode)) // see R5
    else $error("trip level not sampled");
  a_trip_held: assert property (!cal_sample |=> $stable(trip_sel_r)) // see R7
    else $error("trip level changed outside sample");
  a_sense_off: assert property ((state_r == bss_pkg::S_SOFT) |-> !cal_sense_r) // see R7
    else $error("sense still connected in soft-start");
  a_ramp_rate: assert property ((state_r == bss_pkg::S_SOFT && !step_end) // see R8
    |=> $stable(ss_ref_r) || state_r != bss_pkg::S_SOFT)
    else $error("ramp stepped early");
  a_prebias_wait: assert property (!pulses_en_r |=> !hs_r) // see R11
    else $error("pulse before ramp passed feedback");
  a_oc_ends_hs: assert property (oc_pulse |=> !hs_r) // see R16
    else $error("high side still on after overcurrent");
  a_fault_off: assert property ((state_r == bss_pkg::S_FAULT) |-> !hs_r && !ls_r) // see R18
    else $error("gate on during fault timeout");
  a_duty_cap: assert property ((phase_nxt >= bss_pkg::HS_MAX_ON_CYC) |=> !hs_r) // see R21
    else $error("duty above cap");
  a_no_overlap: assert property (!(hs_r && ls_r)) // see R13
    else $error("both gates on");

  ////////////////////////////////////////////////////////////////////////////
  // Timebase, calibration, ramp, pre-bias, protection and counter checks
  a_osc_stop: assert property (!supply_ok |=> phase_r == 6'h00) // see R1 R20
    else $error("switching timebase ran in undervoltage");
  a_trip_map: assert property (cal_sample && // see R6
    overload_trip_current == bss_pkg::CUR_LARGE |=> trip_sel_r == bss_pkg::TRIP_LOW)
    else $error("large sensed current did not pick low level");
  a_ramp_hold: assert property ((state_r == bss_pkg::S_RUN) // see R8
    |=> ss_ref_r == $past(external_reference_pin))
    else $error("reference not held in regulation");
  a_soft_limit: assert property (state_r == bss_pkg::S_SOFT && oc_win && // see R10
    hs_drop_mv > trip_mv |-> oc_pulse)
    else $error("current limit idle in soft-start");
  a_ls_widen: assert property ((period_end && pulses_en_r && !full_sync_r) // see R12
    |=> ls_w_r == $past(ls_w_r) + 6'h01)
    else $error("low-side pulse did not widen");
  a_sync_join: assert property ((active && pulses_en_r && ls_w_r != 6'h00 && meets_hs) // see R13
    |=> full_sync_r)
    else $error("no full sync after edges met");
  a_prebias_sr: assert property ((state_r == bss_pkg::S_SOFT && ramp_top && prebias_high) // see R14
    |=> full_sync_r && pulses_en_r)
    else $error("rectifier not enabled above target");
  a_blank_win: assert property ((phase_r <= bss_pkg::BLANK_CYC) |-> !oc_pulse) // see R15
    else $error("comparator used during blanking");
  a_count_up: assert property ((period_end && active && !fc_trip && // see R17
    (oc_seen_r || oc_pulse)) |=> fc_count == $past(fc_count) + 3'h1)
    else $error("fault counter did not step up");
  a_count_down: assert property ((period_end && active && !oc_seen_r && !oc_pulse && // see R17
    fc_count != '0) |=> fc_count == $past(fc_count) - 3'h1)
    else $error("fault counter did not step down");
  a_count_clear: assert property (!active |=> fc_count == '0) // see R22
    else $error("fault counter kept outside operation");
  a_trip_stops: assert property (fc_trip |=> !hs_r && !ls_r) // see R18
    else $error("gates on after fault declared");
  a_retry: assert property ((to_done && en_ok) // see R19 R22
    |=> state_r == bss_pkg::S_CAL && fc_count == '0)
    else $error("no retry after timeout");

  c_run:   cover property (state_r == bss_pkg::S_SOFT ##1 state_r == bss_pkg::S_RUN);
  c_sync:  cover property ($rose(full_sync_r));
  c_fault: cover property (state_r == bss_pkg::S_FAULT ##1 state_r == bss_pkg::S_CAL);
  c_oc:    cover property (oc_pulse ##1 !hs_r);
  c_prebias: cover property (state_r == bss_pkg::S_SOFT && ramp_top && prebias_high);

endmodule : bss_sequencer

// ---- common/bss_pkg.sv ----
// Constants and types for the buck start-up and fault sequencer.
// Assumes a single 25 MHz clock domain; analog quantities arrive as mV codes.
package bss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and switching timebase
  localparam int        CLK_HZ        = 25_000_000;
  localparam int        SW_HZ         = 600_000;
  localparam int        PH_W          = 6;
  localparam logic [5:0] SW_PERIOD_CYC = 6'(CLK_HZ / SW_HZ);                 // 41 cycles
  localparam int        DUTY_MAX_PCT  = 95;
  localparam logic [5:0] HS_MAX_ON_CYC = 6'((CLK_HZ / SW_HZ) * DUTY_MAX_PCT / 100); // 38
  localparam logic [5:0] BLANK_CYC     = 6'h04;       // Comparator blanking after HS turn-on

  ////////////////////////////////////////////////////////////////////////////
  // Calibration and soft-start timing
  localparam int CYC_PER_US        = CLK_HZ / 1_000_000;
  localparam int CAL_SAMPLE_US     = 1000;
  localparam int CAL_SAMPLE_CYC    = CAL_SAMPLE_US * CYC_PER_US;
  localparam int CAL_END_US        = 1500;
  localparam int CAL_END_CYC       = CAL_END_US * CYC_PER_US;
  localparam int SS_RATE_MV_PER_MS = 250;
  localparam int SS_STEP_CYC       = (CLK_HZ / 1000) / SS_RATE_MV_PER_MS;   // 1 mV per step
  localparam int REF_FULL_MV       = 1500;
  localparam int SS_FULL_US        = 6000;
  localparam int SS_PERIOD_CYC     = SS_FULL_US * CYC_PER_US;
  localparam int TMR_W             = 18;
  localparam int STEP_W            = 7;
  localparam int MV_W              = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Overload trip thresholds in mV
  localparam logic [9:0] TRIP_LOW_MV  = 10'h069;      // 105 mV
  localparam logic [9:0] TRIP_MID_MV  = 10'h0B4;      // 180 mV
  localparam logic [9:0] TRIP_HIGH_MV = 10'h136;      // 310 mV

  ////////////////////////////////////////////////////////////////////////////
  // Fault counting
  localparam int        FC_W            = 3;
  localparam logic [2:0] FAULT_LIMIT     = 3'h7;
  localparam logic [2:0] TIMEOUT_PERIODS = 3'h7;

  typedef enum logic [1:0] {
    TRIP_MID  = 2'h0,
    TRIP_LOW  = 2'h1,
    TRIP_HIGH = 2'h2
  } bss_trip_type;

  // Sensed current out of the error amplifier pin during calibration
  typedef enum logic [1:0] {
    CUR_ZERO  = 2'h0,
    CUR_LARGE = 2'h1,
    CUR_SMALL = 2'h2
  } bss_current_type;

  typedef enum logic [2:0] {
    S_OFF   = 3'h0,
    S_CAL   = 3'h1,
    S_SOFT  = 3'h2,
    S_RUN   = 3'h3,
    S_FAULT = 3'h4
  } bss_state_type;

endpackage : bss_pkg

// ---- core/bss_fault_counter.sv ----
// Up/down overcurrent fault counter, one step per switching period.
// Assumes period_end pulses once per switching cycle from the parent.
`timescale 1ns/1ps
module bss_fault_counter #(
  parameter int FC_W = bss_pkg::FC_W
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            clear,
  input  wire logic            period_end,
  input  wire logic            oc_any,
  output logic [FC_W-1:0]      count,
  output logic                 trip
);

  logic [FC_W-1:0] count_r;
  logic [FC_W-1:0] count_nxt;
  wire             at_zero = (count_r == '0);
  wire             at_max  = (count_r == bss_pkg::FAULT_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Step up after a period with a pulse, down otherwise; floor at zero
  assign count_nxt = clear                 ? '0 :                  // see R22
                     !period_end           ? count_r :
                     (oc_any && !at_max)   ? count_r + 1'b1 :      // see R17
                     (!oc_any && !at_zero) ? count_r - 1'b1 :      // see R17 R22
                     count_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  assign trip  = at_max;                                           // see R18

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_count_floor: assert property (@(posedge clk) disable iff (srst) // see R22
    (period_end && !oc_any && !clear && count_r == '0) |=> count_r == '0)
    else $error("fault counter went below zero");

endmodule : bss_fault_counter

// ---- sim/bss_switch_model.sv ----
// Behavioural model of the external high-side power switch.
// Assumes the bench commands an overload; gate drive comes from the sequencer.
`timescale 1ns/1ps
module bss_switch_model (
  input  wire logic       clk,
  input  wire logic       hs_gate,
  input  wire logic       overload,
  output logic [9:0]      hs_drop_mv
);
  logic [9:0] churn_r = 10'h155;

  ////////////////////////////////////////////////////////////////////////////
  // An off switch gives no usable drop, so the line churns every cycle
  always @(posedge clk) begin
    churn_r <= ~churn_r;
  end

  // Drop is meaningful only while conducting: 400 mV overloaded, 60 mV normal
  assign hs_drop_mv = hs_gate ? (overload ? 10'h190 : 10'h03C) : churn_r;
endmodule : bss_switch_model

// ---- sim/test_buck_startup_fault_sequencer.sv ----
// Self-checking bench for the buck start-up and fault sequencer.
// Assumes shortened calibration and soft-start period parameters.
`timescale 1ns/1ps
module test_buck_startup_fault_sequencer;
  localparam int SAMPLE = 40;
  localparam int CEND   = 60;
  localparam int SSP    = 300;
  typedef struct { logic [1:0] cur; bss_pkg::bss_trip_type lvl; } bss_row_type;
  bss_row_type rows [4] = '{'{2'h0, bss_pkg::TRIP_MID}, '{2'h1, bss_pkg::TRIP_LOW},
                            '{2'h2, bss_pkg::TRIP_HIGH}, '{2'h3, bss_pkg::TRIP_MID}};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        supply_ok = 1'b0;
  logic        enable_n = 1'b1;
  logic [1:0]  cur = 2'h0;
  logic [10:0] ext_ref = 11'h014;
  logic [10:0] fb = 11'h00A;
  logic [5:0]  duty = 6'h14;
  logic        overload = 1'b0;
  logic [9:0]  drop;
  logic        hs, ls, cal, flt, reg_on;
  logic [1:0]  lvl;
  logic [10:0] ss_ref;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n, a, b;

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  bss_sequencer #(.CAL_SAMPLE_CYC(SAMPLE), .CAL_END_CYC(CEND), .SS_PERIOD_CYC(SSP)) u_dut (
    .clk(clk), .srst(srst), .supply_ok(supply_ok), .enable_n(enable_n),
    .overload_trip_current(cur), .external_reference_pin(ext_ref), .feedback_input(fb),
    .duty_cmd(duty), .hs_drop_mv(drop), .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .cal_sense_on(cal), .overload_trip_level(lvl),
    .soft_start_ref(ss_ref), .fault_active(flt), .regulating(reg_on));
  bss_switch_model u_sw (.clk(clk), .hs_gate(hs), .overload(overload), .hs_drop_mv(drop));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // Bounded wait for one status output or the high-side gate; running out ends the run
  task automatic wait_for(input int k, input logic v, input int bound, output int cnt);
    cnt = 0;
    while ((k == 0 ? cal : k == 1 ? reg_on : k == 2 ? flt : hs) !== v) begin
      cyc(1);
      cnt++;
      if (cnt > bound) begin
        chk(16'(k), 16'hFFFF);
        summarize();
      end
    end
  endtask : wait_for

  // Gate on-cycles over one full switching period, any phase alignment
  task automatic count_period(output int h, output int l);
    h = 0;
    l = 0;
    repeat (41) begin
      cyc(1);
      h += int'(hs === 1'b1);
      l += int'(ls === 1'b1);
    end
  endtask : count_period

  task automatic chk_idle();
    chk(16'({hs, ls, cal, flt, reg_on, lvl}), 16'h0000);
    chk(16'(ss_ref), 16'h0000);
  endtask : chk_idle

  // Pre-bias: no high-side pulse while the ramp sits below feedback
  always @(posedge clk) begin
    if (!srst && hs === 1'b1 && 12'(ss_ref) + 12'h001 < 12'(fb)) chk(16'(ss_ref), 16'(fb));
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(19);
    chk_idle();
    @(posedge clk);
    srst <= 1'b0;
    supply_ok <= 1'b1;
    // Trip level selection, one row per strap setting
    foreach (rows[i]) begin
      @(posedge clk);
      cur <= rows[i].cur;
      enable_n <= 1'b1;
      cyc(3);
      @(posedge clk);
      enable_n <= 1'b0;
      wait_for(0, 1'b1, 4, n);
      cyc(SAMPLE + 5);
      chk(16'(lvl), 16'(rows[i].lvl));
      @(posedge clk);
      cur <= rows[(i + 1) % 4].cur;
      wait_for(0, 1'b0, CEND, n);
      chk(16'(lvl), 16'(rows[i].lvl));
    end
    // Ramp of 20 mV at 1 mV per 100 cycles, then hold
    wait_for(1, 1'b1, 2500, n);
    chk(16'(n >= 1900 && n <= 2100), 16'h1);
    cyc(50);
    chk(16'(ss_ref), 16'(ext_ref));
    cyc(2000);
    count_period(a, b);
    chk(16'(a), 16'h14);
    chk(16'(b), 16'h14);  // one dead cycle after high-side fall
    @(posedge clk);
    duty <= 6'h3F;
    cyc(45);
    count_period(a, b);
    chk(16'(a), 16'h26);
    // Alternating overload periods must net to zero in the counter
    // Windows start at a high-side rise so each covers one whole period
    wait_for(3, 1'b0, 41, n);
    wait_for(3, 1'b1, 41, n);
    repeat (20) begin
      @(posedge clk);
      overload <= ~overload;
      cyc(40);
    end
    chk(16'(flt), 16'h0);
    @(posedge clk);
    overload <= 1'b1;
    cyc(82);
    count_period(a, b);
    chk(16'(a >= 5 && a <= 7), 16'h1);
    wait_for(2, 1'b1, 8 * 41, n);
    @(posedge clk);
    overload <= 1'b0;
    a = 0;
    n = 0;
    while (cal !== 1'b1 && n < 7 * SSP + 50) begin
      cyc(1);
      n++;
      a += int'(hs !== 1'b0 || ls !== 1'b0);
    end
    chk(16'(a), 16'h0);
    chk(16'(n >= 7 * SSP - 5 && n <= 7 * SSP + 5), 16'h1);
    wait_for(1, 1'b1, CEND + 2500, n);
    chk(16'(flt), 16'h0);
    // Undervoltage, floating enable, then a reset during calibration
    @(posedge clk);
    supply_ok <= 1'b0;
    cyc(3);
    chk(16'({hs, ls, reg_on}), 16'h0000);
    @(posedge clk);
    supply_ok <= 1'b1;
    enable_n <= 1'b1;
    cyc(100);
    chk(16'(cal), 16'h0);
    @(posedge clk);
    enable_n <= 1'b0;
    wait_for(0, 1'b1, 4, n);
    @(posedge clk);
    srst <= 1'b1;
    cyc(2);
    chk_idle();
    // Second release with output above target: rectifier on, no high side
    @(posedge clk);
    srst <= 1'b0;
    fb <= 11'h01E;
    duty <= 6'h00;
    wait_for(1, 1'b1, CEND + 2500, n);
    count_period(a, b);
    chk(16'(a), 16'h0000);
    chk(16'(b), 16'h0029);
    summarize();
  end
endmodule : test_buck_startup_fault_sequencer
